// File: clk_ctrl_pkg.sv
// constants and types shared by the clock synthesizer control block
package clk_ctrl_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_SKEW = 8'h0A;
	localparam logic [7:0] OFS_WDOG = 8'h0B;
	localparam logic [7:0] OFS_MULT_HI = 8'h0C;
	localparam logic [7:0] OFS_MULT_LO_DIV = 8'h0D;
	localparam logic [7:0] OFS_FSRC = 8'h0E;
	localparam logic [7:0] OFS_FSEL = 8'h08;
	// power-up values
	localparam logic [7:0] RST_SKEW = 8'h0F;
	localparam logic [7:0] RST_WDOG = 8'h00;
	localparam logic [7:0] RST_MULT_HI = 8'h00;
	localparam logic [7:0] RST_MULT_LO_DIV = 8'h00;
	localparam logic [7:0] RST_FSRC = 8'h40;
	localparam logic [7:0] RST_FSEL = 8'h00;
	// field positions
	localparam int BIT_RECOVERY = 6;
	localparam int BIT_RELOAD = 5;
	localparam int BIT_ALARM = 4;
	localparam int BIT_OVERRIDE = 7;
	localparam int BIT_PROG_EN = 0;
	// reserved bits forced on write: byte 10 [3:0]=1, byte 14 [6]=1 [5:1]=0
	localparam logic [7:0] SKEW_RSVD_MASK = 8'h0F;
	localparam logic [7:0] FSRC_KEEP_MASK = 8'h81;
	localparam logic [7:0] FSRC_RSVD_VAL = 8'h40;
	// skew encodings
	localparam logic [1:0] SKEW_NORMAL = 2'h0;
	localparam logic [1:0] SKEW_EARLY = 2'h1;
	localparam logic [1:0] SKEW_RSVD = 2'h2;
	localparam logic [1:0] SKEW_LATE = 2'h3;
	// timing: 10 MHz clock, watchdog step of two seconds
	localparam longint CLK_HZ = 10000000;
	localparam longint WDOG_STEP_S = 2;
	localparam longint WDOG_STEP_CYC = WDOG_STEP_S * CLK_HZ;
	// watchdog states
	typedef enum logic [1:0] {WD_IDLE, WD_RUN, WD_EXPIRED} wdog_state_t;
endpackage : clk_ctrl_pkg

// File: cfg_if.sv
// register write carrier between the control block and its watchdog
`timescale 1ns/1ps
interface cfg_if;
	logic [3:0] period; // watchdog period code
	logic reload; // one-cycle reload pulse
	logic expire; // one-cycle timeout pulse
	modport ctrl (output period, output reload, input expire);
	modport wdog (input period, input reload, output expire);
endinterface : cfg_if

// File: wdog_timer.sv
// watchdog counter with selectable period
`timescale 1ns/1ps
module wdog_timer #(
	parameter longint STEP_CYC = clk_ctrl_pkg::WDOG_STEP_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// control
	cfg_if.wdog cfg
);
	localparam int CW = 36;
	logic [CW-1:0] cnt_ff; // cycles since start or reload
	logic [CW-1:0] limit; // cycles to expiry
	logic expire_ff; // timeout pulse
	clk_ctrl_pkg::wdog_state_t state_ff;
	clk_ctrl_pkg::wdog_state_t nxt_state;
	wire running = (state_ff == clk_ctrl_pkg::WD_RUN);
	wire hit = running && (cnt_ff >= limit - CW'(1));
	// codes above 3 keep two seconds per step
	assign limit = CW'(STEP_CYC) * CW'(cfg.period);
	assign cfg.expire = expire_ff;
	// state selection; period zero disables
	always_comb begin
		case (state_ff)
			clk_ctrl_pkg::WD_IDLE: nxt_state = (cfg.period != 4'h0) ?
				clk_ctrl_pkg::WD_RUN : clk_ctrl_pkg::WD_IDLE;
			clk_ctrl_pkg::WD_RUN: nxt_state = (cfg.period == 4'h0) ? clk_ctrl_pkg::WD_IDLE :
				(hit && !cfg.reload) ? clk_ctrl_pkg::WD_EXPIRED : clk_ctrl_pkg::WD_RUN;
			clk_ctrl_pkg::WD_EXPIRED: nxt_state = (cfg.period == 4'h0) ?
				clk_ctrl_pkg::WD_IDLE : clk_ctrl_pkg::WD_EXPIRED;
			default: nxt_state = clk_ctrl_pkg::WD_IDLE;
		endcase
	end
	// counter restarts from zero on reload while running on
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_ff <= clk_ctrl_pkg::WD_IDLE;
			cnt_ff <= '0;
			expire_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= (!running || cfg.reload) ? '0 : cnt_ff + CW'(1);
			expire_ff <= hit && !cfg.reload;
		end
	end
	// expiry arrives exactly at the selected count
	a_wdog_expiry: assert property (@(posedge ref_clk) disable iff (!nrst)
		expire_ff |-> $past(cnt_ff) == limit - CW'(1) || $changed(cfg.period))
		else $error("watchdog expired at wrong count");
	a_reload_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		cfg.reload |=> cnt_ff == '0)
		else $error("reload did not clear count");
endmodule : wdog_timer

// File: clock_synth_ctrl_watchdog.sv
// control bytes 10 to 14 of the clock synthesizer: skew, watchdog, programmable rate
`timescale 1ns/1ps
module clock_synth_ctrl_watchdog #(
	parameter longint WDOG_STEP_CYC = clk_ctrl_pkg::WDOG_STEP_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// register write/read port from the serial slave
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	// strap pins, latched at the release of reset
	input wire logic [4:0] strap_freq_pins,
	// reboot indication, single cycle from same domain
	input wire logic reboot,
	// skew controls
	output logic [1:0] bus_clock_skew,
	output logic [1:0] mid_clock_skew,
	output logic bus_skew_early,
	output logic bus_skew_late,
	output logic [1:0] mid_skew_step,
	output logic mid_skew_early,
	// frequency controls
	output logic [4:0] active_freq_sel,
	output logic prog_freq_active,
	output logic [8:0] cpu_rate_multiplier,
	output logic [6:0] cpu_rate_divider,
	// watchdog
	output logic wdog_timeout_flag
);
	// register storage
	logic [7:0] skew_ff; // byte 10
	logic [7:0] wdog_ff; // byte 11
	logic [7:0] mult_hi_ff; // byte 12
	logic [7:0] mult_lo_div_ff; // byte 13
	logic [7:0] fsrc_ff; // byte 14
	logic [7:0] fsel_ff; // software frequency code byte
	// values saved for reuse after reboot
	logic [7:0] saved_fsel_ff;
	logic [7:0] saved_fsrc_ff;
	logic [7:0] saved_mult_hi_ff;
	logic [7:0] saved_mult_lo_ff;
	// strap synchroniser and latch
	logic [4:0] strap_s1_ff;
	logic [4:0] strap_s2_ff;
	logic [4:0] strap_lat_ff;
	logic [1:0] strap_wait_ff; // counts sync delay after reset
	// output flops
	logic [7:0] rdata_ff;
	logic [1:0] bus_skew_ff;
	logic [1:0] mid_skew_ff;
	logic bus_early_ff;
	logic bus_late_ff;
	logic [1:0] mid_step_ff;
	logic mid_early_ff;
	logic [4:0] act_sel_ff;
	logic prog_ff;
	logic [8:0] mult_ff;
	logic [6:0] div_ff;
	logic alarm_ff;
	logic prev_reload_ff; // last written reload bit

	cfg_if wcfg ();

	wdog_timer #(.STEP_CYC(WDOG_STEP_CYC)) u_wdog (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.cfg(wcfg)
	);

	// address decode
	wire hit_skew = wr_en && addr == clk_ctrl_pkg::OFS_SKEW;
	wire hit_wdog = wr_en && addr == clk_ctrl_pkg::OFS_WDOG;
	wire hit_mhi = wr_en && addr == clk_ctrl_pkg::OFS_MULT_HI;
	wire hit_mlo = wr_en && addr == clk_ctrl_pkg::OFS_MULT_LO_DIV;
	wire hit_fsrc = wr_en && addr == clk_ctrl_pkg::OFS_FSRC;
	wire hit_fsel = wr_en && addr == clk_ctrl_pkg::OFS_FSEL;
	// reload acts only on a written 0 followed by a written 1
	wire wr_reload = wdata[clk_ctrl_pkg::BIT_RELOAD];
	wire reload_evt = hit_wdog && wr_reload && !prev_reload_ff;
	// clearing the period field clears the alarm
	wire period_clr = hit_wdog && wdata[3:0] == 4'h0;
	// reserved bits forced to their defaults on write
	wire [7:0] skew_wr = wdata | clk_ctrl_pkg::SKEW_RSVD_MASK;
	wire [7:0] fsrc_wr = (wdata & clk_ctrl_pkg::FSRC_KEEP_MASK) |
		clk_ctrl_pkg::FSRC_RSVD_VAL;
	// field extraction
	wire override = fsrc_ff[clk_ctrl_pkg::BIT_OVERRIDE];
	wire prog_en = fsrc_ff[clk_ctrl_pkg::BIT_PROG_EN];
	wire [8:0] mult_w = {mult_hi_ff, mult_lo_div_ff[7]};
	wire [6:0] div_w = mult_lo_div_ff[6:0];
	// gear and ratio selection follows the active source
	wire [4:0] sel_w = override ? fsel_ff[4:0] : strap_lat_ff;
	wire recover_sw = wdog_ff[clk_ctrl_pkg::BIT_RECOVERY];

	// decode a skew code into early / late flags
	function automatic logic [1:0] skew_dir(input logic [1:0] code, input logic mid);
		skew_dir = 2'h0;
		if (code == clk_ctrl_pkg::SKEW_EARLY) skew_dir = 2'h1;
		else if (code == clk_ctrl_pkg::SKEW_LATE) skew_dir = 2'h2;
		else if (mid && code == clk_ctrl_pkg::SKEW_RSVD) skew_dir = 2'h2;
	endfunction : skew_dir

	wire [1:0] bus_dir = skew_dir(skew_ff[7:6], 1'b0);
	wire [1:0] mid_dir = skew_dir(skew_ff[5:4], 1'b1);
	// mid group steps of 150 ps: 0, 1, 1, 2
	wire [1:0] mid_step = (skew_ff[5:4] == clk_ctrl_pkg::SKEW_LATE) ? 2'h2 :
		(skew_ff[5:4] == clk_ctrl_pkg::SKEW_NORMAL) ? 2'h0 : 2'h1;

	// read mux; unmapped offsets read zero
	wire [7:0] rd_mux =
		(addr == clk_ctrl_pkg::OFS_SKEW) ? skew_ff :
		(addr == clk_ctrl_pkg::OFS_WDOG) ? {wdog_ff[7:5], alarm_ff, wdog_ff[3:0]} :
		(addr == clk_ctrl_pkg::OFS_MULT_HI) ? mult_hi_ff :
		(addr == clk_ctrl_pkg::OFS_MULT_LO_DIV) ? mult_lo_div_ff :
		(addr == clk_ctrl_pkg::OFS_FSRC) ? fsrc_ff :
		(addr == clk_ctrl_pkg::OFS_FSEL) ? fsel_ff : 8'h00;

	assign wcfg.period = wdog_ff[3:0];
	assign wcfg.reload = reload_evt;

	// strap pins through two flops before use
	always_ff @(posedge ref_clk) begin
		strap_s1_ff <= strap_freq_pins;
		strap_s2_ff <= strap_s1_ff;
	end

	// latch straps once the synchroniser has settled after reset
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			strap_wait_ff <= 2'h0;
			strap_lat_ff <= 5'h00;
		end else if (strap_wait_ff != 2'h3) begin
			strap_wait_ff <= strap_wait_ff + 2'h1;
			strap_lat_ff <= strap_s2_ff;
		end
	end

	// byte 10 and byte 12/13 writes
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			skew_ff <= clk_ctrl_pkg::RST_SKEW;
			mult_hi_ff <= clk_ctrl_pkg::RST_MULT_HI;
			mult_lo_div_ff <= clk_ctrl_pkg::RST_MULT_LO_DIV;
		end else if (reboot) begin
			// reboot restores saved values only when asked to
			mult_hi_ff <= recover_sw ? saved_mult_hi_ff : clk_ctrl_pkg::RST_MULT_HI;
			mult_lo_div_ff <= recover_sw ? saved_mult_lo_ff : clk_ctrl_pkg::RST_MULT_LO_DIV;
		end else begin
			if (hit_skew) skew_ff <= skew_wr;
			if (hit_mhi) mult_hi_ff <= wdata;
			if (hit_mlo) mult_lo_div_ff <= wdata;
		end
	end

	// frequency source and software code; reboot falls back to straps when bit is 0
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			fsrc_ff <= clk_ctrl_pkg::RST_FSRC;
			fsel_ff <= clk_ctrl_pkg::RST_FSEL;
		end else if (reboot) begin
			fsrc_ff <= recover_sw ? saved_fsrc_ff : clk_ctrl_pkg::RST_FSRC;
			fsel_ff <= recover_sw ? saved_fsel_ff : clk_ctrl_pkg::RST_FSEL;
		end else begin
			if (hit_fsrc) fsrc_ff <= fsrc_wr;
			if (hit_fsel) fsel_ff <= wdata;
		end
	end

	// snapshot of the last software programmed frequency values
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			saved_fsel_ff <= clk_ctrl_pkg::RST_FSEL;
			saved_fsrc_ff <= clk_ctrl_pkg::RST_FSRC;
			saved_mult_hi_ff <= clk_ctrl_pkg::RST_MULT_HI;
			saved_mult_lo_ff <= clk_ctrl_pkg::RST_MULT_LO_DIV;
		end else begin
			if (hit_fsel) saved_fsel_ff <= wdata;
			if (hit_fsrc) saved_fsrc_ff <= fsrc_wr;
			if (hit_mhi) saved_mult_hi_ff <= wdata;
			if (hit_mlo) saved_mult_lo_ff <= wdata;
		end
	end

	// watchdog byte; bit 7 stored as written, software keeps it zero
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wdog_ff <= clk_ctrl_pkg::RST_WDOG;
			prev_reload_ff <= 1'b0;
		end else if (hit_wdog) begin
			wdog_ff <= wdata;
			prev_reload_ff <= wr_reload;
		end
	end

	// alarm: timeout wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!nrst) alarm_ff <= 1'b0;
		else if (wcfg.expire) alarm_ff <= 1'b1;
		else if (period_clr) alarm_ff <= 1'b0;
	end

	// registered outputs
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rdata_ff <= 8'h00;
			bus_skew_ff <= 2'h0;
			mid_skew_ff <= 2'h0;
			bus_early_ff <= 1'b0;
			bus_late_ff <= 1'b0;
			mid_step_ff <= 2'h0;
			mid_early_ff <= 1'b0;
			act_sel_ff <= 5'h00;
			prog_ff <= 1'b0;
			mult_ff <= 9'h000;
			div_ff <= 7'h00;
		end else begin
			rdata_ff <= rd_en ? rd_mux : rdata_ff;
			bus_skew_ff <= skew_ff[7:6];
			mid_skew_ff <= skew_ff[5:4];
			bus_early_ff <= bus_dir[0];
			bus_late_ff <= bus_dir[1];
			mid_step_ff <= mid_step;
			mid_early_ff <= mid_dir[0];
			act_sel_ff <= sel_w;
			prog_ff <= prog_en;
			// downstream pll forms gear * n / m only while enabled
			mult_ff <= prog_en ? mult_w : 9'h000;
			div_ff <= prog_en ? div_w : 7'h00;
		end
	end

	assign rdata = rdata_ff;
	assign bus_clock_skew = bus_skew_ff;
	assign mid_clock_skew = mid_skew_ff;
	assign bus_skew_early = bus_early_ff;
	assign bus_skew_late = bus_late_ff;
	assign mid_skew_step = mid_step_ff;
	assign mid_skew_early = mid_early_ff;
	assign active_freq_sel = act_sel_ff;
	assign prog_freq_active = prog_ff;
	assign cpu_rate_multiplier = mult_ff;
	assign cpu_rate_divider = div_ff;
	assign wdog_timeout_flag = alarm_ff;

	// timeout must raise the alarm on the next edge
	a_alarm_set: assert property (@(posedge ref_clk) disable iff (!nrst)
		wcfg.expire |=> alarm_ff)
		else $error("alarm not set after timeout");
	a_alarm_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		period_clr && !wcfg.expire |=> !alarm_ff)
		else $error("alarm not cleared with period");
	// a second written 1 without a 0 in between must not restart the count
	a_reload_edge: assert property (@(posedge ref_clk) disable iff (!nrst)
		hit_wdog && wr_reload && prev_reload_ff |-> !wcfg.reload)
		else $error("reload without prior zero");
	a_sel_source: assert property (@(posedge ref_clk) disable iff (!nrst)
		##1 act_sel_ff == $past(override ? fsel_ff[4:0] : strap_lat_ff))
		else $error("active selection wrong source");
	a_mult_field: assert property (@(posedge ref_clk) disable iff (!nrst)
		prog_en |=> mult_ff == $past({mult_hi_ff, mult_lo_div_ff[7]}))
		else $error("multiplier field misplaced");
	a_prog_off: assert property (@(posedge ref_clk) disable iff (!nrst)
		!prog_en |=> mult_ff == 9'h000 && div_ff == 7'h00)
		else $error("rate driven while disabled");
	a_bus_skew: assert property (@(posedge ref_clk) disable iff (!nrst)
		skew_ff[7:6] == clk_ctrl_pkg::SKEW_LATE |=> bus_late_ff && !bus_early_ff)
		else $error("bus late skew wrong");
	a_mid_skew: assert property (@(posedge ref_clk) disable iff (!nrst)
		skew_ff[5:4] == clk_ctrl_pkg::SKEW_LATE |=> mid_step_ff == 2'h2)
		else $error("mid late skew wrong");
	a_rsvd_bits: assert property (@(posedge ref_clk) disable iff (!nrst)
		skew_ff[3:0] == 4'hF && fsrc_ff[6:1] == 6'h20)
		else $error("reserved bits lost defaults");
	a_recover_hw: assert property (@(posedge ref_clk) disable iff (!nrst)
		reboot && !recover_sw |=> fsrc_ff == clk_ctrl_pkg::RST_FSRC)
		else $error("reboot did not fall back to straps");
endmodule : clock_synth_ctrl_watchdog

// File: reg_host_model.sv
// register host model that drives the block's byte write and read port
`timescale 1ns/1ps
module reg_host_model (
	// clock
	input wire logic ref_clk,
	// byte port toward the block
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	// bus idle at time zero
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end

	// one byte write; reserved and test bits always sent at their required levels
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == 8'h0A) begin
			v[3:0] = 4'hF;
		end
		if (a == 8'h0B) begin
			v[7] = 1'b0;
		end
		if (a == 8'h0E) begin
			v[6:1] = 6'h20;
		end
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge ref_clk);
		// released lines show the inverse, so stale data never looks valid
		wr_en <= 1'b0;
		addr <= ~a;
		wdata <= ~v;
	endtask : wr

	// one byte read; data is registered on the edge that takes the strobe and sampled one cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		addr <= ~a;
		@(posedge ref_clk);
		#1;
		d = rdata;
	endtask : rd
endmodule : reg_host_model

// File: clock_synth_ctrl_watchdog_tb_top.sv
// self-checking bench for the clock synthesizer control bytes
`timescale 1ns/1ps
module clock_synth_ctrl_watchdog_tb_top;
	localparam longint STEP = 10; // shortened watchdog step, in cycles
	localparam int LIMIT = 4000; // run ceiling, well above the planned sequence
	localparam logic [4:0] STRAPS = 5'h13; // strap level held through reset
	// clock, reset and block ports
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic wr_en;
	logic rd_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [4:0] strap_freq_pins;
	logic reboot;
	logic [1:0] bus_clock_skew;
	logic [1:0] mid_clock_skew;
	logic bus_skew_early;
	logic bus_skew_late;
	logic [1:0] mid_skew_step;
	logic mid_skew_early;
	logic [4:0] active_freq_sel;
	logic prog_freq_active;
	logic [8:0] cpu_rate_multiplier;
	logic [6:0] cpu_rate_divider;
	logic wdog_timeout_flag;
	// bookkeeping
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;

	clock_synth_ctrl_watchdog #(.WDOG_STEP_CYC(STEP)) u_clock_synth_ctrl_watchdog (
		.ref_clk(ref_clk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata), .rdata(rdata), .strap_freq_pins(strap_freq_pins), .reboot(reboot),
		.bus_clock_skew(bus_clock_skew), .mid_clock_skew(mid_clock_skew),
		.bus_skew_early(bus_skew_early), .bus_skew_late(bus_skew_late),
		.mid_skew_step(mid_skew_step), .mid_skew_early(mid_skew_early),
		.active_freq_sel(active_freq_sel), .prog_freq_active(prog_freq_active),
		.cpu_rate_multiplier(cpu_rate_multiplier), .cpu_rate_divider(cpu_rate_divider),
		.wdog_timeout_flag(wdog_timeout_flag));
	reg_host_model u_reg_host_model (.ref_clk(ref_clk), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wdata(wdata), .rdata(rdata));

	// 10 MHz clock
	always #50 ref_clk = ~ref_clk;

	// cycle count; a hang past the ceiling ends the run as a failure
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			errors = errors + 1;
			$display("BAD %0t run did not finish", $time);
			summarize();
		end
	end

	// counts and verdict
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	// value comparison, four-state exact
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string w);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask : check_val

	// timing comparison, in cycles
	task automatic check_time(input int n, input int lo, input int hi, input string w);
		n_compared++;
		if (n < lo || n > hi) begin
			errors++;
			$display("BAD %0t %s took %0d cycles", $time, w, n);
		end
	endtask : check_time

	// read a byte and compare it
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_reg_host_model.rd(a, d);
		check_val(16'(d), 16'(exp), "readback");
	endtask : rdchk

	// register effects reach the outputs one cycle after the write edge
	task automatic settle();
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : settle

	// one-cycle reboot pulse
	task automatic pulse_reboot();
		@(posedge ref_clk);
		reboot <= 1'b1;
		@(posedge ref_clk);
		reboot <= 1'b0;
		settle();
	endtask : pulse_reboot

	// cycles from a write until the alarm shows, bounded
	task automatic wait_flag(input int t0, output int n);
		while (wdog_timeout_flag !== 1'b1 && cyc - t0 < 400) begin
			@(posedge ref_clk);
			#1;
		end
		n = cyc - t0;
	endtask : wait_flag

	// main sequence
	initial begin
		logic [7:0] ofs [6];
		logic [7:0] por [6];
		logic [1:0] mstep [4];
		int per [4];
		int t;
		int n;
		ofs = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h08};
		por = '{8'h0F, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
		mstep = '{2'h0, 2'h1, 2'h1, 2'h2};
		per = '{1, 2, 3, 5};
		strap_freq_pins <= STRAPS;
		reboot <= 1'b0;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (6) @(posedge ref_clk);
		// power-up contents, then an unmapped place
		for (int i = 0; i < 6; i++) begin
			rdchk(ofs[i], por[i]);
		end
		u_reg_host_model.wr(8'h09, 8'hFF);
		rdchk(8'h09, 8'h00);
		check_val(16'(active_freq_sel), 16'(STRAPS), "pins at power-up");
		// every skew code on both groups
		for (int c = 0; c < 4; c++) begin
			u_reg_host_model.wr(8'h0A, {c[1:0], c[1:0], 4'hF});
			settle();
			check_val(16'({bus_clock_skew, bus_skew_early, bus_skew_late}),
				16'({c[1:0], c == 1, c == 3}), "bus skew");
			check_val(16'({mid_clock_skew, mid_skew_early, mid_skew_step}),
				16'({c[1:0], c == 1, mstep[c]}), "mid skew");
			rdchk(8'h0A, {c[1:0], c[1:0], 4'hF});
		end
		// n = 331, m = 48 keeps the ratio above one
		u_reg_host_model.wr(8'h0C, 8'hA5);
		u_reg_host_model.wr(8'h0D, 8'hB0);
		settle();
		check_val({cpu_rate_multiplier, cpu_rate_divider}, 16'h0000, "rate off");
		u_reg_host_model.wr(8'h0E, 8'h01);
		settle();
		check_val(16'(prog_freq_active), 16'h0001, "enable");
		check_val({cpu_rate_multiplier, cpu_rate_divider}, {9'h14B, 7'h30},
			"n m");
		check_val(16'(active_freq_sel), 16'(STRAPS), "ratio by pins");
		u_reg_host_model.wr(8'h08, 8'h0C);
		u_reg_host_model.wr(8'h0E, 8'h81);
		settle();
		check_val(16'(active_freq_sel), 16'h000C, "ratio by code");
		rdchk(8'h0E, 8'hC1);
		// reboot keeps software values, then falls back to the pins
		u_reg_host_model.wr(8'h0B, 8'h40);
		pulse_reboot();
		check_val(16'({prog_freq_active, active_freq_sel}), 16'h002C, "keep sw");
		check_val({cpu_rate_multiplier, cpu_rate_divider}, {9'h14B, 7'h30}, "keep n m");
		u_reg_host_model.wr(8'h0B, 8'h00);
		pulse_reboot();
		check_val(16'({prog_freq_active, active_freq_sel}), 16'(STRAPS), "use pins");
		check_val({cpu_rate_multiplier, cpu_rate_divider}, 16'h0000, "drop n m");
		// period codes 1, 2, 3 and 5 each time out at their step count, alarm clears with the period
		for (int i = 0; i < 4; i++) begin
			u_reg_host_model.wr(8'h0B, 8'(per[i]));
			t = cyc;
			wait_flag(t, n);
			check_time(n, per[i] * STEP, per[i] * STEP + 3, "period");
			rdchk(8'h0B, 8'h10 | 8'(per[i]));
			u_reg_host_model.wr(8'h0B, 8'h00);
			settle();
			check_val(16'(wdog_timeout_flag), 16'h0000, "alarm clear");
		end
		repeat (40) @(posedge ref_clk);
		#1;
		check_val(16'(wdog_timeout_flag), 16'h0000, "watchdog off");
		// reload after 0, then a second 1 that must not reload
		u_reg_host_model.wr(8'h0B, 8'h02);
		repeat (12) @(posedge ref_clk);
		u_reg_host_model.wr(8'h0B, 8'h22);
		t = cyc;
		repeat (8) @(posedge ref_clk);
		u_reg_host_model.wr(8'h0B, 8'h22);
		wait_flag(t, n);
		check_time(n, 2 * STEP, 2 * STEP + 3, "reload");
		u_reg_host_model.wr(8'h0B, 8'h00);
		summarize();
	end
endmodule : clock_synth_ctrl_watchdog_tb_top
